// >>> rtl/tcwp_pkg.sv
// Package of constants and carrier types for the tuner control word port
package tcwp_pkg;

   // ----------------------------------------------------------------
   // Serial target addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] TCWP_ADDR_WRITE = 8'hc0;
   localparam logic [7:0] TCWP_ADDR_READ  = 8'hc1;
   localparam logic [3:0] TCWP_BITS_BYTE  = 4'h8;

   // ----------------------------------------------------------------
   // Byte classification and status byte layout
   // ----------------------------------------------------------------
   localparam int         TCWP_CLASS_MSB   = 7;
   localparam int         TCWP_CLASS_NEXT  = 6;
   localparam int         TCWP_STAT_POR_BIT  = 7;
   localparam int         TCWP_STAT_LOCK_BIT = 6;
   localparam logic [5:0] TCWP_STAT_LOW_ONES = 6'h3f;

   // ----------------------------------------------------------------
   // Decode tables
   // ----------------------------------------------------------------
   localparam logic [6:0] TCWP_AGC_TOP_DBUV  = 7'h72;
   localparam logic [6:0] TCWP_AGC_STEP_DB   = 7'h02;
   localparam logic [2:0] TCWP_AGC_OFF_CODE  = 3'h7;
   localparam logic [7:0] TCWP_REF_RATIO_0   = 8'h18;
   localparam logic [7:0] TCWP_REF_RATIO_1   = 8'h1c;
   localparam logic [7:0] TCWP_REF_RATIO_2   = 8'h30;
   localparam logic [7:0] TCWP_REF_RATIO_3   = 8'h38;
   localparam logic [7:0] TCWP_REF_RATIO_4   = 8'h40;
   localparam logic [7:0] TCWP_REF_RATIO_5   = 8'h60;
   localparam logic [7:0] TCWP_REF_RATIO_6   = 8'h80;
   localparam logic [9:0] TCWP_PUMP_UA_0     = 10'h046;
   localparam logic [9:0] TCWP_PUMP_UA_1     = 10'h08c;
   localparam logic [9:0] TCWP_PUMP_UA_2     = 10'h15e;
   localparam logic [9:0] TCWP_PUMP_UA_3     = 10'h258;
   localparam logic [9:0] TCWP_PUMP_UA_HIGH  = 10'h384;
   // Source current in nA; the high setting needs fourteen bits
   localparam logic [13:0] TCWP_AGC_SRC_NA_LO = 14'h012c;
   localparam logic [13:0] TCWP_AGC_SRC_NA_HI = 14'h2328;
   localparam logic [1:0] TCWP_BAND_VHF_HIGH = 2'h2;
   localparam logic [1:0] TCWP_BAND_UHF      = 2'h0;
   localparam logic [1:0] TCWP_BAND_STANDBY  = 2'h3;

   // ----------------------------------------------------------------
   // Lock discriminator timing
   // ----------------------------------------------------------------
   localparam int         TCWP_CLK_PERIOD_NS   = 100;
   localparam int         TCWP_LOCK_ERR_MAX_NS = 500;
   localparam int         TCWP_LOCK_ERR_CYC    = (TCWP_LOCK_ERR_MAX_NS / TCWP_CLK_PERIOD_NS < 1)
                                               ? 1 : TCWP_LOCK_ERR_MAX_NS / TCWP_CLK_PERIOD_NS;
   localparam int         TCWP_LOCK_GOOD_COUNT = 4;

   // ----------------------------------------------------------------
   // Stored control fields
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [14:0] divider_word;
      logic [2:0]  agc_start_point;
      logic [2:0]  ref_div_select;
      logic [1:0]  pump_current_select;
      logic        agc_detector_source;
      logic        general_port_two;
      logic        general_port_one;
      logic [1:0]  band_select;
      logic        agc_output_current_select;
      logic        mode;
      logic        test3_ifamp_disable;
      logic        test_bit_two;
      logic        test1_pump_msb;
      logic        test_bit_zero;
   } tcwp_ctrl_t;

   localparam tcwp_ctrl_t TCWP_CTRL_RESET = '0;

   // Decoded operating state handed to the analog side
   typedef struct packed {
      logic [7:0] ref_div_ratio;
      logic [9:0] pump_current_ua;
      logic [6:0] agc_threshold_dbuv;
      logic [13:0] agc_source_na;
      logic       agc_enable;
      logic       ifamp_enable;
      logic       test_mode;
      logic       vhf_high_sel;
      logic       uhf_sel;
      logic       standby;
   } tcwp_decoded_t;

   localparam tcwp_decoded_t TCWP_DECODED_RESET = '0;

endpackage

// >>> rtl/tcwp_lock_detect.sv
// Lock discriminator that measures the phase-detector error pulse width
`timescale 1ns/10ps
module tcwp_lock_detect
   import tcwp_pkg::*;
#(
   parameter int ERR_MAX_CYC = TCWP_LOCK_ERR_CYC,
   parameter int GOOD_COUNT  = TCWP_LOCK_GOOD_COUNT
)
(
   // Clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_reset_n,
   // Phase detector error pulse, asynchronous
   input  wire logic i_phase_err,
   // Lock result
   output logic      o_locked
);

   logic       err_s1;
   logic       err_s2;
   logic       err_d;
   logic [7:0] width;
   logic [7:0] good;
   logic [7:0] next_width;
   logic [7:0] next_good;
   logic       next_locked;

   always_comb
   begin
      next_width  = width;
      next_good   = good;
      next_locked = o_locked;
      if (err_s2)
      begin
         if (width <= 8'(ERR_MAX_CYC))
            next_width = width + 8'h01;
         else
         begin
            // A pulse that is already too wide drops lock without waiting for its end
            next_good   = 8'h00;
            next_locked = 1'b0;
         end
      end
      else if (err_d)
      begin
         next_width = 8'h00;
         if (width <= 8'(ERR_MAX_CYC))
         begin
            if (good < 8'(GOOD_COUNT))
               next_good = good + 8'h01;
            if (good >= 8'(GOOD_COUNT - 1))
               next_locked = 1'b1;
         end
         else
         begin
            next_good   = 8'h00;
            next_locked = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         err_s1   <= 1'b0;
         err_s2   <= 1'b0;
         err_d    <= 1'b0;
         width    <= 8'h00;
         good     <= 8'h00;
         o_locked <= 1'b0;
      end
      else
      begin
         err_s1   <= i_phase_err;
         err_s2   <= err_s1;
         err_d    <= err_s2;
         width    <= next_width;
         good     <= next_good;
         o_locked <= next_locked;
      end
   end

endmodule

// >>> rtl/tcwp_top.sv
// Two-wire target port that holds the tuner control word and status byte
//
// Behaviour
// - Acknowledge write address c0 and write bytes
// - Address c1 returns the status byte
// - Divider word fifteen bits, high byte first
// - Control byte one: 10, start point, ref
// - Start point threshold 114..102; 111 disables
// - Reference divider ratio table, 111 reserved
// - Band switch byte field order
// - Pump current table, 900 needs mode
// - Detector source: IF amp or mixer
// - General ports follow written bits
// - Band select VHF-high, UHF, standby
// - Control byte two layout, shared pump bit
// - Gain-control current 300 nA or 9 uA
// - Mode and top test bit gate IF amp
// - Normal versus test mode decode
// - Test mode removes RF gain control
// - Status byte: power-on, lock, six ones
// - Power-on flag cleared after status read
// - Write telegram order, band follows control one
// - Lock flag from error pulse width
`timescale 1ns/10ps
module tcwp_top
   import tcwp_pkg::*;
(
   // Clock and reset
   input  wire logic    i_clk_sys,
   input  wire logic    i_reset_n,
   // Two-wire bus pins
   input  wire logic    i_scl,
   input  wire logic    i_sda,
   output logic         o_sda_out,
   output logic         o_sda_oe,
   // Phase detector error pulse
   input  wire logic    i_phase_err,
   // Stored fields and decoded state
   output tcwp_ctrl_t   o_ctrl,
   output tcwp_decoded_t o_decoded,
   output logic         o_por_flag,
   output logic         o_pll_locked
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_BYTE,
      ST_WR_ACK,
      ST_RD_BYTE,
      ST_RD_ACK
   } tcwp_state_t;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] ref_ratio(input logic [2:0] sel);
      case (sel)
         3'h0:    ref_ratio = TCWP_REF_RATIO_0;
         3'h1:    ref_ratio = TCWP_REF_RATIO_1;
         3'h2:    ref_ratio = TCWP_REF_RATIO_2;
         3'h3:    ref_ratio = TCWP_REF_RATIO_3;
         3'h4:    ref_ratio = TCWP_REF_RATIO_4;
         3'h5:    ref_ratio = TCWP_REF_RATIO_5;
         3'h6:    ref_ratio = TCWP_REF_RATIO_6;
         default: ref_ratio = 8'h00;
      endcase
   endfunction

   function automatic logic [9:0] pump_ua(input tcwp_ctrl_t c);
      logic [2:0] code;
      code = {c.mode & c.test1_pump_msb, c.pump_current_select};
      case (code)
         3'h0:    pump_ua = TCWP_PUMP_UA_0;
         3'h1:    pump_ua = TCWP_PUMP_UA_1;
         3'h2:    pump_ua = TCWP_PUMP_UA_2;
         3'h3:    pump_ua = TCWP_PUMP_UA_3;
         3'h4:    pump_ua = TCWP_PUMP_UA_HIGH;
         default: pump_ua = 10'h000;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] pin_raw;
   logic [1:0] pin_s1;
   logic [1:0] pin_s2;
   logic [1:0] pin_d;

   assign pin_raw = {i_scl, i_sda};

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_sync
         always_ff @(posedge i_clk_sys)
         begin
            if (!i_reset_n)
            begin
               pin_s1[g] <= 1'b1;
               pin_s2[g] <= 1'b1;
               pin_d[g]  <= 1'b1;
            end
            else
            begin
               pin_s1[g] <= pin_raw[g];
               pin_s2[g] <= pin_s1[g];
               pin_d[g]  <= pin_s2[g];
            end
         end
      end
   endgenerate

   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   assign scl       = pin_s2[1];
   assign sda       = pin_s2[0];
   assign scl_rise  = scl & ~pin_d[1];
   assign scl_fall  = ~scl & pin_d[1];
   assign bus_start = scl & pin_d[1] & pin_d[0] & ~sda;
   assign bus_stop  = scl & pin_d[1] & ~pin_d[0] & sda;

   // ----------------------------------------------------------------
   // Serial state
   // ----------------------------------------------------------------
   tcwp_state_t state;
   tcwp_state_t next_state;
   logic [3:0]  bit_cnt;
   logic [3:0]  next_bit_cnt;
   logic [7:0]  shift;
   logic [7:0]  next_shift;
   logic        rd_req;
   logic        next_rd_req;
   logic        master_nack;
   logic        next_master_nack;
   logic        expect_band;
   logic        next_expect_band;
   logic        expect_div_low;
   logic        next_expect_div_low;
   logic        next_sda_oe;
   logic        next_por_flag;
   tcwp_ctrl_t  next_ctrl;
   logic        locked;
   logic [7:0]  status_byte;

   always_comb
   begin
      status_byte                   = '1;
      status_byte[TCWP_STAT_POR_BIT]  = o_por_flag;
      status_byte[TCWP_STAT_LOCK_BIT] = locked;
      status_byte[5:0]                = TCWP_STAT_LOW_ONES;
   end

   always_comb
   begin
      next_state          = state;
      next_bit_cnt        = bit_cnt;
      next_shift          = shift;
      next_rd_req         = rd_req;
      next_master_nack    = master_nack;
      next_expect_band    = expect_band;
      next_expect_div_low = expect_div_low;
      next_sda_oe         = o_sda_oe;
      next_por_flag       = o_por_flag;
      next_ctrl           = o_ctrl;
      if (bus_start)
      begin
         next_state          = ST_ADDR;
         next_bit_cnt        = 4'h0;
         next_sda_oe         = 1'b0;
         next_expect_band    = 1'b0;
         next_expect_div_low = 1'b0;
      end
      else if (bus_stop)
      begin
         next_state  = ST_IDLE;
         next_sda_oe = 1'b0;
      end
      else
      begin
         case (state)
            ST_ADDR,
            ST_WR_BYTE:
            begin
               if (scl_rise && bit_cnt < TCWP_BITS_BYTE)
               begin
                  next_shift   = {shift[6:0], sda};
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               else if (scl_fall && bit_cnt == TCWP_BITS_BYTE)
               begin
                  if (state == ST_WR_BYTE)
                  begin
                     next_state  = ST_WR_ACK;
                     next_sda_oe = 1'b1;
                  end
                  else if (shift == TCWP_ADDR_WRITE || shift == TCWP_ADDR_READ)
                  begin
                     next_state  = ST_ADDR_ACK;
                     next_sda_oe = 1'b1;
                     next_rd_req = shift[0];
                  end
                  else
                     next_state = ST_IDLE;
               end
            end
            ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  next_bit_cnt = 4'h0;
                  if (rd_req)
                  begin
                     next_state  = ST_RD_BYTE;
                     next_shift  = status_byte;
                     next_sda_oe = ~status_byte[7];
                  end
                  else
                  begin
                     next_state  = ST_WR_BYTE;
                     next_sda_oe = 1'b0;
                  end
               end
            end
            ST_WR_ACK:
            begin
               if (scl_fall)
               begin
                  // Fields change only once the acknowledge slot is over
                  next_state   = ST_WR_BYTE;
                  next_bit_cnt = 4'h0;
                  next_sda_oe  = 1'b0;
                  if (expect_band)
                  begin
                     next_expect_band              = 1'b0;
                     next_ctrl.pump_current_select = shift[7:6];
                     next_ctrl.agc_detector_source = shift[5];
                     next_ctrl.general_port_two    = shift[3];
                     next_ctrl.general_port_one    = shift[2];
                     next_ctrl.band_select         = shift[1:0];
                  end
                  else if (expect_div_low)
                  begin
                     next_expect_div_low         = 1'b0;
                     next_ctrl.divider_word[7:0] = shift;
                  end
                  else if (!shift[TCWP_CLASS_MSB])
                  begin
                     next_expect_div_low          = 1'b1;
                     next_ctrl.divider_word[14:8] = shift[6:0];
                  end
                  else if (!shift[TCWP_CLASS_NEXT])
                  begin
                     next_expect_band          = 1'b1;
                     next_ctrl.agc_start_point = shift[5:3];
                     next_ctrl.ref_div_select  = shift[2:0];
                  end
                  else
                  begin
                     next_ctrl.agc_output_current_select = shift[5];
                     next_ctrl.mode                      = shift[4];
                     next_ctrl.test3_ifamp_disable       = shift[3];
                     next_ctrl.test_bit_two              = shift[2];
                     next_ctrl.test1_pump_msb            = shift[1];
                     next_ctrl.test_bit_zero             = shift[0];
                  end
               end
            end
            ST_RD_BYTE:
            begin
               if (scl_rise && bit_cnt < TCWP_BITS_BYTE)
                  next_bit_cnt = bit_cnt + 4'h1;
               else if (scl_fall)
               begin
                  if (bit_cnt == TCWP_BITS_BYTE)
                  begin
                     next_state  = ST_RD_ACK;
                     next_sda_oe = 1'b0;
                  end
                  else
                  begin
                     next_shift  = {shift[6:0], 1'b1};
                     next_sda_oe = ~shift[6];
                  end
               end
            end
            ST_RD_ACK:
            begin
               if (scl_rise)
               begin
                  next_master_nack = sda;
                  next_por_flag    = 1'b0;
               end
               else if (scl_fall)
               begin
                  next_bit_cnt = 4'h0;
                  if (master_nack)
                     next_state = ST_IDLE;
                  else
                  begin
                     // The status byte repeats for as long as the master acknowledges
                     next_state  = ST_RD_BYTE;
                     next_shift  = status_byte;
                     next_sda_oe = ~status_byte[7];
                  end
               end
            end
            default:
               next_state = ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Decoded operating state
   // ----------------------------------------------------------------
   tcwp_decoded_t next_decoded;
   logic          test_mode;

   always_comb
   begin
      // A clear mode bit with both upper test bits clear counts as normal
      test_mode = ~o_ctrl.mode
                & (o_ctrl.test3_ifamp_disable | o_ctrl.test_bit_two);
      next_decoded                 = TCWP_DECODED_RESET;
      next_decoded.ref_div_ratio   = ref_ratio(o_ctrl.ref_div_select);
      next_decoded.pump_current_ua = pump_ua(o_ctrl);
      next_decoded.agc_threshold_dbuv = TCWP_AGC_TOP_DBUV
         - 7'(TCWP_AGC_STEP_DB * {4'h0, o_ctrl.agc_start_point});
      next_decoded.agc_source_na   = o_ctrl.agc_output_current_select
                                   ? TCWP_AGC_SRC_NA_HI : TCWP_AGC_SRC_NA_LO;
      next_decoded.agc_enable      = (o_ctrl.agc_start_point != TCWP_AGC_OFF_CODE)
                                   & ~test_mode;
      next_decoded.ifamp_enable    = ~o_ctrl.mode | ~o_ctrl.test3_ifamp_disable;
      next_decoded.test_mode       = test_mode;
      next_decoded.vhf_high_sel    = (o_ctrl.band_select == TCWP_BAND_VHF_HIGH);
      next_decoded.uhf_sel         = (o_ctrl.band_select == TCWP_BAND_UHF);
      next_decoded.standby         = (o_ctrl.band_select == TCWP_BAND_STANDBY);
   end

   tcwp_lock_detect tcwp_lock_detect_i
   (
      .i_clk_sys   (i_clk_sys),
      .i_reset_n   (i_reset_n),
      .i_phase_err (i_phase_err),
      .o_locked    (locked)
   );

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         state          <= ST_IDLE;
         bit_cnt        <= 4'h0;
         shift          <= 8'h00;
         rd_req         <= 1'b0;
         master_nack    <= 1'b0;
         expect_band    <= 1'b0;
         expect_div_low <= 1'b0;
         o_sda_out      <= 1'b0;
         o_sda_oe       <= 1'b0;
         o_por_flag     <= 1'b1;
         o_ctrl         <= TCWP_CTRL_RESET;
         o_decoded      <= TCWP_DECODED_RESET;
         o_pll_locked   <= 1'b0;
      end
      else
      begin
         state          <= next_state;
         bit_cnt        <= next_bit_cnt;
         shift          <= next_shift;
         rd_req         <= next_rd_req;
         master_nack    <= next_master_nack;
         expect_band    <= next_expect_band;
         expect_div_low <= next_expect_div_low;
         o_sda_out      <= 1'b0;
         o_sda_oe       <= next_sda_oe;
         o_por_flag     <= next_por_flag;
         o_ctrl         <= next_ctrl;
         o_decoded      <= next_decoded;
         o_pll_locked   <= locked;
      end
   end

endmodule

// >>> tb/tcwp_props.sv
// Port checker for the tuner control word port
`timescale 1ns/10ps
module tcwp_props
   import tcwp_pkg::*;
(
   input  wire logic          i_clk_sys,
   input  wire logic          i_reset_n,
   input  wire logic          i_scl,
   input  wire logic          i_sda,
   input  wire logic          o_sda_out,
   input  wire logic          o_sda_oe,
   input  wire logic          i_phase_err,
   input  wire tcwp_ctrl_t    o_ctrl,
   input  wire tcwp_decoded_t o_decoded,
   input  wire logic          o_por_flag,
   input  wire logic          o_pll_locked
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);

   sda_value_low_a: assert property (o_sda_out == 1'b0)
      else $error("data pin value not low");
   por_stays_clear_a: assert property (!o_por_flag |=> !o_por_flag)
      else $error("power-on flag set again");
   ref_ratio_top_a: assert property (o_ctrl.ref_div_select == 3'h6 |=>
      o_decoded.ref_div_ratio == 8'h80) else $error("ratio for code 6 wrong");
   standby_band_a: assert property (o_ctrl.band_select == 2'h3 |=>
      o_decoded.standby && !o_decoded.uhf_sel) else $error("standby decode wrong");
   test_mode_a: assert property (!o_ctrl.mode && (o_ctrl.test3_ifamp_disable ||
      o_ctrl.test_bit_two) |=> o_decoded.test_mode && !o_decoded.agc_enable)
      else $error("test mode decode wrong");
   ifamp_off_a: assert property (o_ctrl.mode && o_ctrl.test3_ifamp_disable |=>
      !o_decoded.ifamp_enable) else $error("amplifier not disabled");
   pump_high_a: assert property (o_ctrl.mode && o_ctrl.test1_pump_msb &&
      o_ctrl.pump_current_select == 2'h0 |=> o_decoded.pump_current_ua == 10'h384)
      else $error("high pump current wrong");
   start_point_a: assert property (o_ctrl.agc_start_point == 3'h6 |=>
      o_decoded.agc_threshold_dbuv == 7'h66) else $error("start point wrong");
endmodule

bind tcwp_top tcwp_props tcwp_props_i (.i_clk_sys, .i_reset_n, .i_scl, .i_sda, .o_sda_out,
   .o_sda_oe, .i_phase_err, .o_ctrl, .o_decoded, .o_por_flag, .o_pll_locked);

// >>> tb/tcwp_master.sv
// Two-wire bus master model driving the serial clock and data pins
`timescale 1ns/10ps
module tcwp_master
(
   // Clock and resolved data line
   input  wire logic i_clk_sys,
   input  wire logic i_sda,
   // Bus pins, data is open drain
   output logic      o_scl,
   output logic      o_sda_low
);
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // Quarter bit: SCL high and low each last four clocks
   task automatic q;
      repeat (2) @(posedge i_clk_sys);
   endtask
   task automatic start;
      o_sda_low <= 1'b1;
      q();
      o_scl <= 1'b0;
      q();
   endtask
   task automatic stop;
      o_sda_low <= 1'b1;
      q();
      o_scl <= 1'b1;
      q();
      o_sda_low <= 1'b0;
      q();
   endtask
   // Sampled mid-high, well after the target's data change
   task automatic bit_io(input logic b, output logic r);
      o_sda_low <= !b;
      q();
      o_scl <= 1'b1;
      q();
      r = i_sda;
      q();
      o_scl <= 1'b0;
      q();
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rd_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(nack, r);
   endtask
endmodule

// >>> tb/tb_tcwp_top.sv
// Self-checking bench for the tuner control word port
`timescale 1ns/10ps
module tb_tcwp_top;
   import tcwp_pkg::*;
   logic          i_clk_sys = 1'b0;
   logic          i_reset_n = 1'b0;
   logic          i_phase_err = 1'b0;
   wire           scl;
   wire           sda_low;
   logic          o_sda_out;
   logic          o_sda_oe;
   logic          o_por_flag;
   logic          o_pll_locked;
   tcwp_ctrl_t    o_ctrl;
   tcwp_decoded_t o_decoded;
   wire           sda = ~(sda_low | o_sda_oe);
   int            bad_count = 0;
   int            tests_run = 0;
   logic          ack;
   logic [7:0]    rd;
   logic [7:0]    ctl2_v [3] = '{8'hd8, 8'hc4, 8'hc2};
   logic [2:0]    ctl2_e [3] = '{3'b001, 3'b110, 3'b101};

   always #50 i_clk_sys = ~i_clk_sys;

   tcwp_top tcwp_top_i (.i_clk_sys, .i_reset_n, .i_scl(scl), .i_sda(sda), .o_sda_out,
      .o_sda_oe, .i_phase_err, .o_ctrl, .o_decoded, .o_por_flag, .o_pll_locked);
   tcwp_master tcwp_master_i (.i_clk_sys, .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] b);
      tcwp_master_i.wr_byte(b, ack);
      check(ack, 1'b1);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic t_read(input logic [7:0] exp);
      tcwp_master_i.start();
      tcwp_master_i.wr_byte(TCWP_ADDR_READ, ack);
      check(ack, 1'b1);
      tcwp_master_i.rd_byte(1'b1, rd);
      tcwp_master_i.stop();
      check(rd, exp);
      check(o_por_flag, 1'b0);
      $display("read test done");
   endtask
   task automatic t_write_all;
      tcwp_master_i.start();
      wr(TCWP_ADDR_WRITE);
      // Divider 2645 stays inside the legal word range
      wr(8'h0a);
      wr(8'h55);
      wr(8'hb6);
      wr(8'hea);
      wr(8'hf0);
      tcwp_master_i.stop();
      check(o_ctrl, {15'h0a55, 3'h6, 3'h6, 2'h3, 3'b110, 2'h2, 6'b110000});
      check(o_decoded.agc_threshold_dbuv, 7'h66);
      check(o_decoded.pump_current_ua, 10'h258);
      check({o_decoded.vhf_high_sel, o_decoded.ifamp_enable}, 2'b11);
      check(o_decoded.agc_source_na, 14'h2328);
      // Wrong address: no ack and nothing stored
      tcwp_master_i.start();
      tcwp_master_i.wr_byte(8'hc2, ack);
      check(ack, 1'b0);
      tcwp_master_i.wr_byte(8'hc0, ack);
      check(ack, 1'b0);
      tcwp_master_i.stop();
      check(o_ctrl.mode, 1'b1);
      $display("write test done");
   endtask
   task automatic t_pair;
      // Band byte with a zero top bit must not be taken as a divider byte
      tcwp_master_i.start();
      wr(TCWP_ADDR_WRITE);
      wr(8'h80);
      wr(8'h03);
      wr(8'hf2);
      tcwp_master_i.stop();
      check(o_ctrl.divider_word, 15'h0a55);
      check({o_ctrl.general_port_two, o_ctrl.general_port_one}, 2'b00);
      check(o_decoded.standby, 1'b1);
      check(o_decoded.pump_current_ua, 10'h384);
      check(o_decoded.ref_div_ratio, 8'h18);
      for (int i = 0; i < 3; i++)
      begin
         tcwp_master_i.start();
         wr(TCWP_ADDR_WRITE);
         wr(ctl2_v[i]);
         tcwp_master_i.stop();
         check(o_ctrl.agc_output_current_select, 1'b0);
         check(o_decoded.agc_source_na, 14'h012c);
         check({o_decoded.ifamp_enable, o_decoded.test_mode, o_decoded.agc_enable},
            ctl2_e[i]);
      end
      $display("pairing and mode test done");
   endtask
   task automatic t_lock;
      repeat (5)
      begin
         i_phase_err <= 1'b1;
         repeat (2) @(posedge i_clk_sys);
         i_phase_err <= 1'b0;
         repeat (4) @(posedge i_clk_sys);
      end
      repeat (6) @(posedge i_clk_sys);
      check(o_pll_locked, 1'b1);
      t_read(8'h7f);
      i_phase_err <= 1'b1;
      repeat (8) @(posedge i_clk_sys);
      i_phase_err <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      check(o_pll_locked, 1'b0);
      $display("lock test done");
   endtask

   initial
   begin
      repeat (4) @(posedge i_clk_sys);
      check(o_ctrl, '0);
      check(o_por_flag, 1'b1);
      i_reset_n <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      check({o_decoded.ref_div_ratio, o_decoded.uhf_sel}, {8'h18, 1'b1});
      t_read(8'hbf);
      t_write_all();
      t_pair();
      t_lock();
      print_verdict();
   end
   // Bounded run: a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge i_clk_sys);
      bad_count++;
      print_verdict();
   end
endmodule
